// [bench/gp_timer_main_counter_tb.sv]
// self-checking bench of the timer main counter, integer model alongside
// assumes the design package is compiled first; bench masters the AXI4-Lite bus
`timescale 1ns/10ps
module gp_timer_main_counter_tb;
   // ==========================================
   // stimulus and design
   logic MCLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic CNT_CLK0, CNT_CLK1, DBG_HALT;
   logic [11:0] AWADDR, ARADDR;
   logic [31:0] WDATA;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, UPPER_EVT, IRQ;
   logic [1:0] BRESP, RRESP;
   logic [31:0] RDATA;
   int miscompares, tests_run, evt_seen, evt_exp;
   int mode, dbg_act, pre, dv, src, dbg, flag, mask, rawc, nt;
   bit [31:0] cnt, lim, shd, val;

   gp_timer_main_counter uut (.MCLK(MCLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .AWADDR(AWADDR), .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
      .WSTRB(4'hf), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY),
      .RDATA(RDATA), .RRESP(RRESP), .CNT_CLK0(CNT_CLK0), .CNT_CLK1(CNT_CLK1),
      .DBG_HALT(DBG_HALT), .UPPER_EVT(UPPER_EVT), .IRQ(IRQ));

   initial begin
      MCLK = 1'b0;
      forever #2.5 MCLK = ~MCLK;
   end

   always @(posedge MCLK) begin
      if (UPPER_EVT === 1'b1) evt_seen++;
   end

   // ==========================================
   // checking and closing
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ==========================================
   // bus master; only the watchdog ends a wait for an answer
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge MCLK);
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      AWADDR <= a;
      WDATA <= d;
      BREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         if (AWVALID && AWREADY) AWVALID <= 1'b0;
         if (WVALID && WREADY) WVALID <= 1'b0;
      end while (!BVALID);
      r = BRESP;
      BREADY <= 1'b0;
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge MCLK);
      ARVALID <= 1'b1;
      ARADDR <= a;
      RREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         if (ARVALID && ARREADY) ARVALID <= 1'b0;
      end while (!RVALID);
      d = RDATA;
      r = RRESP;
      RREADY <= 1'b0;
   endtask

   // ==========================================
   // model
   task automatic restart();
      cnt = 0;
      rawc = 0;
      nt = 0;
      lim = shd;
      if (mode < 2) val = 0;
   endtask

   task automatic mdl_tick();
      rawc++;
      if (rawc == (pre + 1) << dv) begin
         rawc = 0;
         nt++;
         if (cnt == lim) begin
            cnt = 0;
            lim = shd;
            flag = 1;
            evt_exp++;
         end else cnt++;
         if (mode == 1 || (mode == 0 && nt % 4 == 0)) val = cnt;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r, e;
      e = gp_timer_pkg::RESP_OKAY;
      axi_wr(a, d, r);
      case (a)
         gp_timer_pkg::CNT_CONTROL_OFF: begin
            mode = d[9:8];
            dbg_act = d[4];
         end
         gp_timer_pkg::CNT_COMMAND_OFF: if (d[0]) restart();
         gp_timer_pkg::CNT_STATUS_OFF: if (d[16]) flag = 0;
         gp_timer_pkg::CNT_MASK_OFF: mask = d[16];
         gp_timer_pkg::CNT_UPPER_OFF: shd = d;
         gp_timer_pkg::CLK_CONTROL_OFF: begin
            pre = d[23:16];
            dv = d[11:8];
            src = d[0];
         end
         default: e = gp_timer_pkg::RESP_SLVERR;
      endcase
      chk({30'h0, r}, {30'h0, e});
   endtask

   task automatic rd_chk(input logic [11:0] a);
      logic [31:0] d, e;
      logic [1:0] r, er;
      er = gp_timer_pkg::RESP_OKAY;
      case (a)
         gp_timer_pkg::CNT_CONTROL_OFF: e = (mode << 8) | (dbg_act << 4);
         gp_timer_pkg::CNT_COMMAND_OFF: e = 32'h0;
         gp_timer_pkg::CNT_STATUS_OFF: e = flag << 16;
         gp_timer_pkg::CNT_MASK_OFF: e = mask << 16;
         gp_timer_pkg::CNT_VALUE_OFF: e = val;
         gp_timer_pkg::CNT_UPPER_OFF: e = shd;
         gp_timer_pkg::CLK_CONTROL_OFF: e = (pre << 16) | (dv << 8) | src;
         default: begin
            e = 32'h0;
            er = gp_timer_pkg::RESP_SLVERR;
         end
      endcase
      axi_rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
   endtask

   // unselected clock toggles at random to show it is ignored
   // raw ticks six bus cycles apart keep fast copy mode legal
   task automatic tick(input int n);
      bit o;
      repeat (n) begin
         o = $urandom_range(1, 0);
         @(posedge MCLK);
         {CNT_CLK1, CNT_CLK0} <= src ? {1'b1, o} : {o, 1'b1};
         repeat (3) @(posedge MCLK);
         {CNT_CLK1, CNT_CLK0} <= 2'h0;
         repeat (2) @(posedge MCLK);
         if (!(dbg && !dbg_act)) mdl_tick();
      end
      repeat (2) @(posedge MCLK);
   endtask

   task automatic irq_chk();
      chk({31'h0, IRQ}, {31'h0, flag && !mask[0]});
      chk(evt_seen, evt_exp);
   endtask

   // ==========================================
   // sequence
   initial begin
      {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, CNT_CLK0, CNT_CLK1, DBG_HALT} = 9'h0;
      AWADDR = 12'h0;
      ARADDR = 12'h0;
      WDATA = 32'h0;
      void'($urandom(27));
      {mode, dbg_act, pre, dv, src, dbg, flag, rawc, nt, cnt, val} = '0;
      {miscompares, tests_run, evt_seen, evt_exp} = '0;
      mask = 1;
      shd = gp_timer_pkg::UPPER_RST;
      lim = shd;
      repeat (16) @(posedge MCLK);
      RST_N <= 1'b1;
      for (int a = 12'h040; a <= 12'h084; a += 4) rd_chk(a[11:0]);
      irq_chk();
      $display("test reset done");
      // fast copy, random prescaler, divider and source, free running
      wr(gp_timer_pkg::CNT_CONTROL_OFF, 32'h100);
      repeat (4) begin
         wr(gp_timer_pkg::CLK_CONTROL_OFF, ($urandom_range(3, 0) << 16) | ($urandom_range(2, 0) << 8)
            | $urandom_range(1, 0));
         wr(gp_timer_pkg::CNT_COMMAND_OFF, 32'h1);
         tick($urandom_range(40, 8));
         rd_chk(gp_timer_pkg::CNT_VALUE_OFF);
      end
      $display("test scaling done");
      // wrap and shadowed limit
      wr(gp_timer_pkg::CLK_CONTROL_OFF, 32'h0);
      wr(gp_timer_pkg::CNT_UPPER_OFF, 32'h5);
      wr(gp_timer_pkg::CNT_COMMAND_OFF, 32'h1);
      tick(4);
      wr(gp_timer_pkg::CNT_UPPER_OFF, 32'h2);
      rd_chk(gp_timer_pkg::CNT_UPPER_OFF);
      tick(2);
      rd_chk(gp_timer_pkg::CNT_VALUE_OFF);
      irq_chk();
      wr(gp_timer_pkg::CNT_MASK_OFF, 32'h0);
      irq_chk();
      wr(gp_timer_pkg::CNT_STATUS_OFF, 32'h10000);
      irq_chk();
      tick(3);
      rd_chk(gp_timer_pkg::CNT_STATUS_OFF);
      irq_chk();
      wr(gp_timer_pkg::CNT_MASK_OFF, 32'h10000);
      irq_chk();
      tick(2);
      rd_chk(gp_timer_pkg::CNT_VALUE_OFF);
      $display("test limit done");
      // debug halt and debug action
      dbg = 1;
      DBG_HALT <= 1'b1;
      tick(5);
      rd_chk(gp_timer_pkg::CNT_VALUE_OFF);
      wr(gp_timer_pkg::CNT_CONTROL_OFF, 32'h110);
      tick(5);
      rd_chk(gp_timer_pkg::CNT_VALUE_OFF);
      dbg = 0;
      DBG_HALT <= 1'b0;
      $display("test debug done");
      // normal, fast, reserved and off copy modes
      wr(gp_timer_pkg::CNT_UPPER_OFF, gp_timer_pkg::UPPER_RST);
      for (int m = 0; m < 4; m++) begin
         wr(gp_timer_pkg::CNT_CONTROL_OFF, m << 8);
         rd_chk(gp_timer_pkg::CNT_CONTROL_OFF);
         tick(3);
         rd_chk(gp_timer_pkg::CNT_VALUE_OFF);
         tick(3);
         rd_chk(gp_timer_pkg::CNT_VALUE_OFF);
      end
      wr(12'h070, 32'h1);
      rd_chk(12'h070);
      irq_chk();
      $display("test modes done");
      finish_test();
   end

   initial begin
      repeat (40000) @(posedge MCLK);
      miscompares++;
      finish_test();
   end
endmodule // gp_timer_main_counter_tb

// [design/gp_timer_main_counter.sv]
// main up-counter of the general purpose timer with its AXI4-Lite registers
// assumes counter clocks and debug level are synchronous to MCLK
`timescale 1ns/10ps
module gp_timer_main_counter #(
   parameter int CNT_W = 32,
   parameter int ADDR_W = 12
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [ADDR_W-1:0] AWADDR,
   input wire logic [2:0] AWPROT,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic [2:0] ARPROT,
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   input wire logic CNT_CLK0,
   input wire logic CNT_CLK1,
   input wire logic DBG_HALT,
   output logic UPPER_EVT,
   output logic IRQ
);

   // ==========================================
   // elaboration checks
   if (CNT_W != 32 || ADDR_W < 8 || ADDR_W > 32) begin : g_bad_param
      $error("counter width must be 32 and address width 8 to 32");
   end

   // ==========================================
   // helpers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      logic [11:0] o;
      o = 12'(a);
      return (a[ADDR_W-1:0] == ADDR_W'(o)) &&
         (o == gp_timer_pkg::CNT_CONTROL_OFF || o == gp_timer_pkg::CNT_COMMAND_OFF ||
          o == gp_timer_pkg::CNT_STATUS_OFF || o == gp_timer_pkg::CNT_MASK_OFF ||
          o == gp_timer_pkg::CNT_VALUE_OFF || o == gp_timer_pkg::CNT_UPPER_OFF ||
          o == gp_timer_pkg::CLK_CONTROL_OFF);
   endfunction

   // ==========================================
   // state
   gp_timer_pkg::cnt_cfg_s cfg_r;
   gp_timer_pkg::clk_cfg_s clk_r;
   logic [31:0] cnt_r, cnt_nxt, val_r, shadow_r, limit_r, wdata_r, rdata_r;
   logic [31:0] cfg_img, clk_img, cfg_wr, clk_wr;
   logic [7:0] pre_cnt_r;
   logic [14:0] div_cnt_r, div_mask;
   logic [1:0] upd_cnt_r, bresp_r, rresp_r;
   logic [3:0] wstrb_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic src_d_r, upper_sts_r, upper_msk_r, upper_evt_r, aw_held_r, w_held_r, bvalid_r, rvalid_r;
   logic [11:0] wr_off;
   logic do_write, restart, src_lvl, src_rise, run, pre_hit, tick, reach, copy;

   // ==========================================
   // write channel: address and data taken in either order
   assign AWREADY = !aw_held_r && !bvalid_r;
   assign WREADY = !w_held_r && !bvalid_r;
   assign do_write = aw_held_r && w_held_r && !bvalid_r;
   assign wr_off = 12'(awaddr_r);

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_held_r <= 1'b0;
         awaddr_r <= '0;
      end else if (AWVALID && AWREADY) begin
         aw_held_r <= 1'b1;
         awaddr_r <= AWADDR;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         w_held_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (WVALID && WREADY) begin
         w_held_r <= 1'b1;
         wdata_r <= WDATA;
         wstrb_r <= WSTRB;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         bvalid_r <= 1'b0;
         bresp_r <= gp_timer_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r <= mapped(awaddr_r) ? gp_timer_pkg::RESP_OKAY : gp_timer_pkg::RESP_SLVERR;
      end else if (BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   assign BVALID = bvalid_r;
   assign BRESP = bresp_r;

   // ==========================================
   // read channel: one cycle to data
   assign ARREADY = !rvalid_r;

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= gp_timer_pkg::RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         rvalid_r <= 1'b1;
         rresp_r <= mapped(ARADDR) ? gp_timer_pkg::RESP_OKAY : gp_timer_pkg::RESP_SLVERR;
         rdata_r <= '0;
         unique case (12'(ARADDR))
            gp_timer_pkg::CNT_CONTROL_OFF: rdata_r <= cfg_img;
            gp_timer_pkg::CNT_STATUS_OFF: rdata_r[gp_timer_pkg::UPPER_FLAG_BIT] <= upper_sts_r;
            gp_timer_pkg::CNT_MASK_OFF: rdata_r[gp_timer_pkg::UPPER_FLAG_BIT] <= upper_msk_r;
            gp_timer_pkg::CNT_VALUE_OFF: rdata_r <= val_r;
            gp_timer_pkg::CNT_UPPER_OFF: rdata_r <= shadow_r;
            gp_timer_pkg::CLK_CONTROL_OFF: rdata_r <= clk_img;
            default: rdata_r <= '0;
         endcase
      end else if (RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   assign RVALID = rvalid_r;
   assign RDATA = rdata_r;
   assign RRESP = rresp_r;

   // ==========================================
   // configuration registers; reserved bits read zero and are dropped on write
   assign cfg_img = (32'(cfg_r.mode) << gp_timer_pkg::UPDT_MODE_LSB) |
      (32'(cfg_r.dbg_act) << gp_timer_pkg::DBG_ACT_BIT);
   assign clk_img = (32'(clk_r.pre) << gp_timer_pkg::PRE_LSB) | (32'(clk_r.div) << gp_timer_pkg::DIV_LSB) |
      (32'(clk_r.src) << gp_timer_pkg::SRC_BIT);
   assign cfg_wr = merge(cfg_img, wdata_r, wstrb_r);
   assign clk_wr = merge(clk_img, wdata_r, wstrb_r);

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_r <= '{mode: gp_timer_pkg::UPDT_NORMAL, dbg_act: 1'b0};
      end else if (do_write && wr_off == gp_timer_pkg::CNT_CONTROL_OFF) begin
         cfg_r.mode <= gp_timer_pkg::updt_mode_e'(cfg_wr[gp_timer_pkg::UPDT_MODE_LSB +: 2]);
         cfg_r.dbg_act <= cfg_wr[gp_timer_pkg::DBG_ACT_BIT];
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         clk_r <= '0;
      end else if (do_write && wr_off == gp_timer_pkg::CLK_CONTROL_OFF) begin
         clk_r.pre <= clk_wr[gp_timer_pkg::PRE_LSB +: 8];
         clk_r.div <= clk_wr[gp_timer_pkg::DIV_LSB +: 4];
         clk_r.src <= clk_wr[gp_timer_pkg::SRC_BIT];
      end
   end

   // zero is never a legal limit; the counter would wrap every tick
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         shadow_r <= gp_timer_pkg::UPPER_RST;
      end else if (do_write && wr_off == gp_timer_pkg::CNT_UPPER_OFF) begin
         shadow_r <= merge(shadow_r, wdata_r, wstrb_r);
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         upper_msk_r <= gp_timer_pkg::MASK_RST;
      end else if (do_write && wr_off == gp_timer_pkg::CNT_MASK_OFF && wstrb_r[2]) begin
         upper_msk_r <= wdata_r[gp_timer_pkg::UPPER_FLAG_BIT];
      end
   end

   assign restart = do_write && wr_off == gp_timer_pkg::CNT_COMMAND_OFF && wstrb_r[0] &&
      wdata_r[gp_timer_pkg::RESTART_BIT];

   // ==========================================
   // tick chain: source edge, prescaler, power-of-two divider
   assign src_lvl = clk_r.src ? CNT_CLK1 : CNT_CLK0;
   assign run = !DBG_HALT || cfg_r.dbg_act;
   assign src_rise = src_lvl && !src_d_r && run;
   assign pre_hit = src_rise && pre_cnt_r == clk_r.pre;
   assign div_mask = 15'((16'h1 << clk_r.div) - 16'h1);
   assign tick = pre_hit && div_cnt_r == div_mask;
   assign reach = tick && cnt_r == limit_r && !restart;

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         src_d_r <= 1'b0;
      end else begin
         src_d_r <= src_lvl;
      end
   end

   // a divisor change mid-period takes effect at once; a stage already past its new end restarts from zero
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         pre_cnt_r <= '0;
      end else if (restart || pre_hit || pre_cnt_r > clk_r.pre) begin
         pre_cnt_r <= '0;
      end else if (src_rise) begin
         pre_cnt_r <= pre_cnt_r + 8'h1;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         div_cnt_r <= '0;
      end else if (restart || tick || div_cnt_r > div_mask) begin
         div_cnt_r <= '0;
      end else if (pre_hit) begin
         div_cnt_r <= div_cnt_r + 15'h1;
      end
   end

   // ==========================================
   // main counter and active limit
   always_comb begin
      cnt_nxt = cnt_r;
      if (restart) begin
         cnt_nxt = '0;
      end else if (reach) begin
         cnt_nxt = '0;
      end else if (tick) begin
         cnt_nxt = cnt_r + 32'h1;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cnt_r <= '0;
         upper_evt_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         upper_evt_r <= reach;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         limit_r <= gp_timer_pkg::UPPER_RST;
      end else if (restart || reach) begin
         limit_r <= shadow_r;
      end
   end

   assign UPPER_EVT = upper_evt_r;

   // ==========================================
   // readable value mirror; the fixed phase saves a copy on one tick in four
   assign copy = (cfg_r.mode == gp_timer_pkg::UPDT_FAST && (tick || restart)) ||
      (cfg_r.mode == gp_timer_pkg::UPDT_NORMAL &&
       ((tick && upd_cnt_r == gp_timer_pkg::NORMAL_COPY_PHASE) || restart));

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         upd_cnt_r <= '0;
      end else if (restart) begin
         upd_cnt_r <= '0;
      end else if (tick) begin
         upd_cnt_r <= upd_cnt_r + 2'h1;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         val_r <= '0;
      end else if (copy) begin
         val_r <= cnt_nxt;
      end
   end

   // ==========================================
   // sticky flag and interrupt; a new event beats a clear
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         upper_sts_r <= 1'b0;
      end else begin
         upper_sts_r <= (upper_sts_r && !(do_write && wr_off == gp_timer_pkg::CNT_STATUS_OFF && wstrb_r[2] &&
            wdata_r[gp_timer_pkg::UPPER_FLAG_BIT])) || reach;
      end
   end

   assign IRQ = upper_sts_r && !upper_msk_r;

   // ==========================================
   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   norm_update_a: assert property (
      cfg_r.mode == gp_timer_pkg::UPDT_NORMAL && tick && upd_cnt_r != 2'h3 && !restart |=> $stable(val_r))
      else $error("normal mode copied off phase");
   fast_update_a: assert property (
      cfg_r.mode == gp_timer_pkg::UPDT_FAST && tick |=> val_r == cnt_r)
      else $error("fast mode missed a tick");
   update_off_a: assert property (
      cfg_r.mode == gp_timer_pkg::UPDT_OFF |=> $stable(val_r))
      else $error("value changed with update off");
   debug_halt_a: assert property (
      DBG_HALT && !cfg_r.dbg_act && !restart |=> $stable(cnt_r))
      else $error("counter moved in debug");
   wrap_zero_a: assert property (
      reach |=> cnt_r == 32'h0 && UPPER_EVT)
      else $error("no wrap at upper limit");
   shadow_load_a: assert property (
      reach |=> limit_r == $past(shadow_r))
      else $error("shadow not applied at wrap");
   restart_load_a: assert property (
      restart |=> cnt_r == 32'h0 && limit_r == $past(shadow_r) ##1 pre_cnt_r <= clk_r.pre)
      else $error("counter reset did not load limit");
   increment_a: assert property (
      tick && !reach && !restart |=> cnt_r == $past(cnt_r) + 32'h1)
      else $error("count not incremented");
   tick_cause_a: assert property (
      tick |-> src_rise && pre_cnt_r == clk_r.pre && div_cnt_r == div_mask)
      else $error("tick without full division");
   flag_set_a: assert property (
      reach |=> upper_sts_r ##0 (IRQ == !upper_msk_r))
      else $error("event flag not set");

   wrap_seen_c: cover property (reach ##[1:20] reach);
   restart_seen_c: cover property (restart ##1 tick);
   irq_seen_c: cover property ($rose(IRQ));

endmodule // gp_timer_main_counter

// [design/gp_timer_pkg.sv]
// constants, field layouts and carriers of the timer main counter
// assumes an AXI4-Lite master and one clock for bus and counter logic
// Contract
// - mode 0 copies one count per four ticks
// - mode 1 copies every tick; slow clock only
// - mode 3 stops copying; 2 is reserved
// - debug halts counter unless debug action set
// - count readable as 32-bit value, resets zero
// - upper limit resets all ones, free running
// - at upper limit wrap to zero, raise event
// - limit write shadowed, applied at upper event
// - counter reset loads shadowed limit at once
// - prescaler divides counter clock by value+1
// - divider divides by two to the value
// - source bit picks clock 0 or 1
// - upper event sets sticky flag, masked reset
package gp_timer_pkg;

   // ==========================================
   // register map
   localparam logic [11:0] CNT_CONTROL_OFF = 12'h040;
   localparam logic [11:0] CNT_COMMAND_OFF = 12'h044;
   localparam logic [11:0] CNT_STATUS_OFF = 12'h048;
   localparam logic [11:0] CNT_MASK_OFF = 12'h04c;
   localparam logic [11:0] CNT_VALUE_OFF = 12'h050;
   localparam logic [11:0] CNT_UPPER_OFF = 12'h060;
   localparam logic [11:0] CLK_CONTROL_OFF = 12'h080;

   // ==========================================
   // field positions
   localparam int UPDT_MODE_LSB = 8;
   localparam int DBG_ACT_BIT = 4;
   localparam int RESTART_BIT = 0;
   localparam int UPPER_FLAG_BIT = 16;
   localparam int PRE_LSB = 16;
   localparam int DIV_LSB = 8;
   localparam int SRC_BIT = 0;

   // ==========================================
   // reset values
   localparam logic [31:0] UPPER_RST = 32'hffffffff;
   localparam logic MASK_RST = 1'b1;

   // ==========================================
   // answers and normal copy phase
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] NORMAL_COPY_PHASE = 2'h3;

   typedef enum logic [1:0] {
      UPDT_NORMAL,
      UPDT_FAST,
      UPDT_RSVD,
      UPDT_OFF
   } updt_mode_e;

   typedef struct packed {
      logic [7:0] pre;
      logic [3:0] div;
      logic src;
   } clk_cfg_s;

   typedef struct packed {
      updt_mode_e mode;
      logic dbg_act;
   } cnt_cfg_s;

endpackage
